/* cps_pair_status.sv */
// Functional notes
// R01: Terminal count interrupt only while enable set; counter_irq obeys it, but irq fires on terminal count through the mask alone
// R02: Writing reset bit one resets that counter
// R03: Gate bits show gate after polarity
// R04: Bank bits show load bank in use
// R05: Capture valid bit set after hardware latch
// R06: Serial bit high during serial conversion
// R07: Two gate edges without source set stale
// R08: Sticky stale bit holds until cleared
// R09: Second unacknowledged terminal count sets overrun
// R10: Missed reload flag; load or reset clears
//
// Design decision made here: the address-and-strobe port.
module cps_pair_status
   import cps_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic [1:0] gate_pin,
   input wire logic [1:0] gate_invert,
   input wire logic [1:0] source_pin,
   input wire logic [1:0] terminal_count,
   input wire logic [1:0] load_bank_in_use,
   input wire logic [1:0] hw_capture_latch,
   input wire logic [1:0] hw_capture_read,
   input wire logic serial_busy,
   input wire logic [1:0] output_readback,
   input wire logic [1:0] counter_armed,
   input wire logic [1:0] load_command,
   input wire logic [1:0] load_done,
   output logic [1:0] counter_soft_reset,
   output logic [1:0] counter_irq,
   output logic irq
);
   logic [1:0] gate_s1_reg, gate_s2_reg, gate_s3_reg, src_s1_reg, src_s2_reg, src_s3_reg;
   logic [1:0] irq_en_reg, irq_en_next;
   logic [1:0] hw_valid_reg, hw_valid_next;
   logic [IRQ_W-1:0] ists_reg, ists_next, imask_reg, imask_next;
   logic [1:0] rst_next, cirq_next;
   logic irq_next;
   logic [DATA_W-1:0] rdata_next;
   logic [1:0] stale, sticky, overrun, missed, pending, ack_tc, ack_ovr;
   logic [1:0] gate_lvl, gate_edge, src_edge;
   logic wr_ack;
   logic [1:0] ovr_prev_reg, stale_prev_reg, ovr_rise, stale_rise;
   logic [2:0] prime_reg;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
      return reg_write && (a == ofs);
   endfunction : hit

   // Gate seen after polarity, edges of either direction count
   assign gate_lvl = gate_s2_reg ^ gate_invert; // R03
   // Edges wait until all three stages hold pin samples, so a pin high at reset is no edge
   assign gate_edge = (gate_s2_reg ^ gate_s3_reg) & {2{prime_reg[2]}};
   assign src_edge = src_s2_reg & ~src_s3_reg & {2{prime_reg[2]}};
   // Level flags raise one event each; a run of stale edges raises only one
   assign ovr_rise = overrun & ~ovr_prev_reg;
   assign stale_rise = stale & ~stale_prev_reg;
   assign wr_ack = hit(reg_addr, OFS_ACK);
   assign ack_tc = wr_ack ? reg_wdata[POS_TC_ACK +: 2] : 2'b00;
   assign ack_ovr = wr_ack ? reg_wdata[POS_OVR_CLR +: 2] : 2'b00;

   for (genvar i = 0; i < 2; i++) begin : g_cnt
      cps_counter_flags u_flags (
         .clock(clock),
         .arst_n(arst_n),
         .soft_reset(counter_soft_reset[i]),
         .gate_edge(gate_edge[i]),
         .source_edge(src_edge[i]),
         .terminal_count(terminal_count[i]),
         .tc_ack(ack_tc[i]),
         .overrun_clear(ack_ovr[i]),
         .load_command(load_command[i]),
         .load_done(load_done[i]),
         .stale_flag(stale[i]),
         .sticky_stale_flag(sticky[i]),
         .terminal_count_overrun(overrun[i]),
         .missed_reload_flag(missed[i]),
         .tc_pending(pending[i])
      );
   end

   always_comb begin
      irq_en_next = irq_en_reg;
      imask_next = imask_reg;
      hw_valid_next = hw_valid_reg;
      rst_next = 2'b00;
      rdata_next = RESET_VAL;
      if (hit(reg_addr, OFS_IRQ_ENABLE)) begin
         irq_en_next = {reg_wdata[POS_TC_EN1], reg_wdata[POS_TC_EN0]};
      end
      if (hit(reg_addr, OFS_IRQ_MASK)) begin
         imask_next = reg_wdata[IRQ_W-1:0];
      end
      if (hit(reg_addr, OFS_COUNTER_RESET)) begin
         rst_next = reg_wdata[POS_RESET +: 2]; // R02
      end
      // Read of capture clears valid; a new latch in the same cycle wins
      hw_valid_next = (hw_valid_reg & ~hw_capture_read) | hw_capture_latch; // R05
      // Write one to clear; new events win over the clear
      ists_next = ists_reg;
      if (hit(reg_addr, OFS_IRQ_STATUS)) begin
         ists_next = ists_reg & ~reg_wdata[IRQ_W-1:0];
      end
      ists_next = ists_next | {ovr_rise, stale_rise, terminal_count};
      cirq_next = terminal_count & irq_en_reg; // R01
      irq_next = |(ists_next & imask_next);
      if (reg_read) begin
         case (reg_addr)
            OFS_PAIR_STATUS: begin
               rdata_next[POS_ARMED +: 2] = counter_armed;
               rdata_next[POS_MISSED +: 2] = missed; // R10
               rdata_next[POS_OVERRUN +: 2] = overrun; // R09
               rdata_next[POS_STALE +: 2] = stale; // R07
            end
            OFS_GATE_BANK: begin
               rdata_next[POS_BANK +: 2] = load_bank_in_use; // R04
               rdata_next[POS_GATE +: 2] = gate_lvl; // R03
               rdata_next[POS_SERIAL] = serial_busy; // R06
            end
            OFS_SAVE_OUTPUT: begin
               rdata_next[POS_OUTPUT +: 2] = output_readback;
               rdata_next[POS_HWSAVE +: 2] = hw_valid_reg; // R05
               rdata_next[POS_STICKY +: 2] = sticky; // R08
            end
            OFS_IRQ_ENABLE: begin
               rdata_next[POS_TC_EN0] = irq_en_reg[0];
               rdata_next[POS_TC_EN1] = irq_en_reg[1];
            end
            OFS_IRQ_STATUS: begin
               rdata_next[IRQ_W-1:0] = ists_reg;
            end
            OFS_IRQ_MASK: begin
               rdata_next[IRQ_W-1:0] = imask_reg;
            end
            default: begin
               rdata_next = RESET_VAL;
            end
         endcase
      end
   end

   // Sticky bits survive a counter reset so software still sees past errors
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         gate_s1_reg <= 2'b00;
         gate_s2_reg <= 2'b00;
         gate_s3_reg <= 2'b00;
         src_s1_reg <= 2'b00;
         src_s2_reg <= 2'b00;
         src_s3_reg <= 2'b00;
         prime_reg <= 3'b000;
         ovr_prev_reg <= 2'b00;
         stale_prev_reg <= 2'b00;
         irq_en_reg <= 2'b00;
         imask_reg <= '0;
         ists_reg <= '0;
         hw_valid_reg <= 2'b00;
         counter_soft_reset <= 2'b00;
         counter_irq <= 2'b00;
         irq <= 1'b0;
         reg_rdata <= RESET_VAL;
      end else begin
         gate_s1_reg <= gate_pin;
         gate_s2_reg <= gate_s1_reg;
         gate_s3_reg <= gate_s2_reg;
         src_s1_reg <= source_pin;
         src_s2_reg <= src_s1_reg;
         src_s3_reg <= src_s2_reg;
         prime_reg <= {prime_reg[1:0], 1'b1};
         ovr_prev_reg <= overrun;
         stale_prev_reg <= stale;
         irq_en_reg <= irq_en_next;
         imask_reg <= imask_next;
         ists_reg <= ists_next;
         hw_valid_reg <= hw_valid_next;
         counter_soft_reset <= rst_next;
         counter_irq <= cirq_next;
         irq <= irq_next;
         reg_rdata <= rdata_next;
      end
   end

   chk_tc_irq_gate: assert property (@(posedge clock) disable iff (!arst_n) // R01
      counter_irq[0] |-> $past(terminal_count[0]) && $past(irq_en_reg[0]))
      else $error("counter interrupt without enable");
   chk_soft_reset: assert property (@(posedge clock) disable iff (!arst_n) // R02
      hit(reg_addr, OFS_COUNTER_RESET) && reg_wdata[POS_RESET] |=> counter_soft_reset[0])
      else $error("counter reset not issued");
   chk_gate_read: assert property (@(posedge clock) disable iff (!arst_n) // R03
      reg_read && reg_addr == OFS_GATE_BANK |=> reg_rdata[POS_GATE +: 2] == $past(gate_lvl))
      else $error("gate level readback wrong");
   chk_bank_read: assert property (@(posedge clock) disable iff (!arst_n) // R04
      reg_read && reg_addr == OFS_GATE_BANK |=>
      reg_rdata[POS_BANK +: 2] == $past(load_bank_in_use))
      else $error("bank readback wrong");
   chk_hw_valid: assert property (@(posedge clock) disable iff (!arst_n) // R05
      hw_capture_latch[1] |=> hw_valid_reg[1])
      else $error("capture valid not set");
   chk_serial_read: assert property (@(posedge clock) disable iff (!arst_n) // R06
      reg_read && reg_addr == OFS_GATE_BANK |=> reg_rdata[POS_SERIAL] == $past(serial_busy))
      else $error("serial status wrong");
   chk_tc_irq_gate1: assert property (@(posedge clock) disable iff (!arst_n) // R01
      counter_irq[1] |-> $past(terminal_count[1]) && $past(irq_en_reg[1]))
      else $error("counter 1 interrupt without enable");
   chk_tc_irq_fire: assert property (@(posedge clock) disable iff (!arst_n) // R01
      terminal_count[0] && irq_en_reg[0] |=> counter_irq[0])
      else $error("enabled terminal count gave no interrupt");
   chk_soft_reset1: assert property (@(posedge clock) disable iff (!arst_n) // R02
      hit(reg_addr, OFS_COUNTER_RESET) && reg_wdata[POS_RESET + 1] |=> counter_soft_reset[1])
      else $error("counter 1 reset not issued");
   chk_reset_idle: assert property (@(posedge clock) disable iff (!arst_n) // R02
      !hit(reg_addr, OFS_COUNTER_RESET) |=> counter_soft_reset == 2'b00)
      else $error("counter reset without a write");
   chk_hw_valid0: assert property (@(posedge clock) disable iff (!arst_n) // R05
      hw_capture_latch[0] |=> hw_valid_reg[0])
      else $error("capture valid 0 not set");
   chk_sticky_read: assert property (@(posedge clock) disable iff (!arst_n) // R08
      reg_read && (reg_addr == OFS_SAVE_OUTPUT) |=> reg_rdata[POS_STICKY +: 2] == $past(sticky))
      else $error("sticky stale readback wrong");
   chk_missed_read: assert property (@(posedge clock) disable iff (!arst_n) // R10
      reg_read && (reg_addr == OFS_PAIR_STATUS) |=> reg_rdata[POS_MISSED +: 2] == $past(missed))
      else $error("missed reload readback wrong");
endmodule : cps_pair_status

/* cps_pkg.sv */
package cps_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam logic [11:0] OFS_PAIR_STATUS = 12'h008;
   localparam logic [11:0] OFS_GATE_BANK = 12'h036;
   localparam logic [11:0] OFS_SAVE_OUTPUT = 12'h03A;
   localparam logic [11:0] OFS_COUNTER_RESET = 12'h090;
   localparam logic [11:0] OFS_IRQ_ENABLE = 12'h092;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h094;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h098;
   localparam logic [11:0] OFS_ACK = 12'h09C;
   // Pair status fields, counter 0 at the lower bit
   localparam int POS_ARMED = 8;
   localparam int POS_MISSED = 10;
   localparam int POS_OVERRUN = 12;
   localparam int POS_STALE = 6;
   // Joint status 1
   localparam int POS_BANK = 0;
   localparam int POS_GATE = 2;
   localparam int POS_SERIAL = 12;
   // Joint status 2
   localparam int POS_OUTPUT = 0;
   localparam int POS_HWSAVE = 12;
   localparam int POS_STICKY = 14;
   // Joint reset and interrupt enable
   localparam int POS_RESET = 2;
   localparam int POS_TC_EN0 = 6;
   localparam int POS_TC_EN1 = 9;
   // Acknowledge: overrun clear bits, then tc acknowledge bits
   localparam int POS_OVR_CLR = 0;
   localparam int POS_TC_ACK = 2;
   // Interrupt status events: tc(1:0), stale(3:2), overrun(5:4)
   localparam int IRQ_W = 6;
   localparam logic [15:0] RESET_VAL = 16'h0000;
endpackage : cps_pkg

/* cps_counter_flags.sv */
module cps_counter_flags
   import cps_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic soft_reset,
   input wire logic gate_edge,
   input wire logic source_edge,
   input wire logic terminal_count,
   input wire logic tc_ack,
   input wire logic overrun_clear,
   input wire logic load_command,
   input wire logic load_done,
   output logic stale_flag,
   output logic sticky_stale_flag,
   output logic terminal_count_overrun,
   output logic missed_reload_flag,
   output logic tc_pending
);
   logic gate_seen_reg, gate_seen_next;
   logic loaded_reg, loaded_next;
   logic stale_next, sticky_next, ovr_next, missed_next, pend_next;

   always_comb begin
      gate_seen_next = gate_seen_reg;
      loaded_next = loaded_reg | load_done;
      stale_next = stale_flag;
      sticky_next = sticky_stale_flag;
      ovr_next = terminal_count_overrun;
      missed_next = missed_reload_flag;
      pend_next = tc_pending;
      if (source_edge) begin
         gate_seen_next = 1'b0;
      end
      if (gate_edge) begin
         // Two gate edges with no source edge between them
         stale_next = gate_seen_reg & ~source_edge; // R07
         gate_seen_next = 1'b1;
         if (!loaded_reg && !load_done) begin
            missed_next = 1'b1; // R10
         end
         loaded_next = 1'b0;
      end
      if (stale_next) begin
         sticky_next = 1'b1; // R08
      end
      if (overrun_clear) begin
         ovr_next = 1'b0;
      end
      if (tc_ack) begin
         pend_next = 1'b0;
      end
      if (terminal_count) begin
         // Set beats a clear in the same cycle
         if (tc_pending && !tc_ack) begin
            ovr_next = 1'b1; // R09
         end
         pend_next = 1'b1;
      end
      if ((load_command || soft_reset) && !gate_edge) begin
         missed_next = 1'b0; // R10
      end
      if (soft_reset) begin
         gate_seen_next = 1'b0;
         stale_next = 1'b0;
         ovr_next = 1'b0;
         pend_next = 1'b0;
         loaded_next = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         gate_seen_reg <= 1'b0;
         loaded_reg <= 1'b0;
         stale_flag <= 1'b0;
         sticky_stale_flag <= 1'b0;
         terminal_count_overrun <= 1'b0;
         missed_reload_flag <= 1'b0;
         tc_pending <= 1'b0;
      end else begin
         gate_seen_reg <= gate_seen_next;
         loaded_reg <= loaded_next;
         stale_flag <= stale_next;
         sticky_stale_flag <= sticky_next;
         terminal_count_overrun <= ovr_next;
         missed_reload_flag <= missed_next;
         tc_pending <= pend_next;
      end
   end

   chk_overrun_set: assert property (@(posedge clock) disable iff (!arst_n) // R09
      terminal_count && tc_pending && !tc_ack && !soft_reset |=> terminal_count_overrun)
      else $error("overrun not set on second terminal count");
   chk_stale_set: assert property (@(posedge clock) disable iff (!arst_n) // R07
      gate_edge && gate_seen_reg && !source_edge && !soft_reset |=> stale_flag)
      else $error("stale flag not set");
   chk_sticky_hold: assert property (@(posedge clock) disable iff (!arst_n) // R08
      stale_flag |=> sticky_stale_flag [*3])
      else $error("sticky stale flag lost");
   chk_missed_clear: assert property (@(posedge clock) disable iff (!arst_n) // R10
      (load_command || soft_reset) && !gate_edge |=> !missed_reload_flag)
      else $error("missed reload flag not cleared");
endmodule : cps_counter_flags

/* tb_cps_pair_status.sv */
module tb_cps_pair_status;
   import cps_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
   logic clock, arst_n, reg_write, reg_read, serial_busy, irq;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
   logic [1:0] gate_pin, gate_invert, source_pin, terminal_count, load_bank_in_use;
   logic [1:0] hw_capture_latch, hw_capture_read, output_readback, counter_armed;
   logic [1:0] load_command, load_done, counter_soft_reset, counter_irq;
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;
   cps_pair_status dut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .gate_pin(gate_pin), .gate_invert(gate_invert),
      .source_pin(source_pin), .terminal_count(terminal_count),
      .load_bank_in_use(load_bank_in_use), .hw_capture_latch(hw_capture_latch),
      .hw_capture_read(hw_capture_read), .serial_busy(serial_busy),
      .output_readback(output_readback), .counter_armed(counter_armed),
      .load_command(load_command), .load_done(load_done),
      .counter_soft_reset(counter_soft_reset), .counter_irq(counter_irq), .irq(irq));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Generous ceiling; the whole sequence needs fewer than two hundred cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         stop_test();
      end
   end
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clock);
      reg_write <= 1'b1; reg_addr <= a; reg_wdata <= v;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge clock);
      reg_read <= 1'b1; reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : wait_cyc
   task automatic tc(input logic [1:0] v);
      @(posedge clock);
      terminal_count <= v;
      @(posedge clock);
      terminal_count <= 2'b00;
      #1;
   endtask : tc
   task automatic t_reset_values;
      rd(OFS_PAIR_STATUS); `CHK(d, 16'h0000)
      rd(OFS_SAVE_OUTPUT); `CHK(d, 16'h0000)
      rd(12'h0FE); `CHK(d, 16'h0000)
      $display("test reset_values done");
   endtask : t_reset_values
   task automatic t_live_status;
      gate_pin <= 2'b01; gate_invert <= 2'b10; load_bank_in_use <= 2'b10;
      serial_busy <= 1'b1; output_readback <= 2'b01; counter_armed <= 2'b10;
      wait_cyc(4);
      rd(OFS_GATE_BANK);
      `CHK(d[POS_GATE +: 2], 2'b11)
      `CHK(d[POS_BANK +: 2], 2'b10)
      `CHK(d[POS_SERIAL], 1'b1)
      rd(OFS_SAVE_OUTPUT); `CHK(d[POS_OUTPUT +: 2], 2'b01)
      rd(OFS_PAIR_STATUS); `CHK(d[POS_ARMED +: 2], 2'b10)
      gate_invert <= 2'b01; load_bank_in_use <= 2'b01; serial_busy <= 1'b0;
      counter_armed <= 2'b00;
      wait_cyc(4);
      rd(OFS_GATE_BANK);
      `CHK(d[POS_GATE +: 2], 2'b00)
      `CHK(d[POS_BANK +: 2], 2'b01)
      `CHK(d[POS_SERIAL], 1'b0)
      $display("test live_status done");
   endtask : t_live_status
   task automatic t_soft_reset;
      wr(OFS_COUNTER_RESET, 16'h0004); #1 `CHK(counter_soft_reset, 2'b01)
      wr(OFS_COUNTER_RESET, 16'h0008); #1 `CHK(counter_soft_reset, 2'b10)
      wr(OFS_PAIR_STATUS, 16'h000C); #1 `CHK(counter_soft_reset, 2'b00)
      $display("test soft_reset done");
   endtask : t_soft_reset
   task automatic t_tc_irq;
      wr(OFS_IRQ_ENABLE, 16'h0040);
      rd(OFS_IRQ_ENABLE); `CHK(d, 16'h0040)
      tc(2'b01); `CHK(counter_irq, 2'b01)
      wr(OFS_ACK, 16'h0004);
      tc(2'b10); `CHK(counter_irq, 2'b00)
      wr(OFS_ACK, 16'h0008);
      wr(OFS_IRQ_ENABLE, 16'h0200);
      tc(2'b10); `CHK(counter_irq, 2'b10)
      wr(OFS_ACK, 16'h0008);
      wr(OFS_IRQ_MASK, 16'h003F); wait_cyc(3);
      `CHK(irq, 1'b1)
      rd(OFS_IRQ_MASK); `CHK(d, 16'h003F)
      wr(OFS_IRQ_MASK, 16'h0000); wait_cyc(3);
      `CHK(irq, 1'b0)
      wr(OFS_IRQ_MASK, 16'h003F);
      wr(OFS_IRQ_STATUS, 16'h003F); wait_cyc(3);
      `CHK(irq, 1'b0)
      rd(OFS_IRQ_STATUS); `CHK(d[IRQ_W-1:0], 6'h00)
      wr(OFS_IRQ_MASK, 16'h0000);
      $display("test tc_irq done");
   endtask : t_tc_irq
   task automatic t_overrun;
      tc(2'b01); wr(OFS_ACK, 16'h0004); tc(2'b01);
      rd(OFS_PAIR_STATUS); `CHK(d[POS_OVERRUN +: 2], 2'b00)
      tc(2'b01);
      rd(OFS_PAIR_STATUS); `CHK(d[POS_OVERRUN +: 2], 2'b01)
      rd(OFS_IRQ_STATUS); `CHK(d[5:4], 2'b01)
      wr(OFS_IRQ_STATUS, 16'h0010);
      rd(OFS_IRQ_STATUS); `CHK(d[5:4], 2'b00)
      wr(OFS_ACK, 16'h0005);
      rd(OFS_PAIR_STATUS); `CHK(d[POS_OVERRUN +: 2], 2'b00)
      $display("test overrun done");
   endtask : t_overrun
   task automatic t_capture;
      @(posedge clock) hw_capture_latch <= 2'b10;
      @(posedge clock) hw_capture_latch <= 2'b00;
      rd(OFS_SAVE_OUTPUT); `CHK(d[POS_HWSAVE +: 2], 2'b10)
      @(posedge clock) hw_capture_read <= 2'b10;
      @(posedge clock) hw_capture_read <= 2'b00;
      rd(OFS_SAVE_OUTPUT); `CHK(d[POS_HWSAVE +: 2], 2'b00)
      $display("test capture done");
   endtask : t_capture
   task automatic t_gate_flags;
      wr(OFS_COUNTER_RESET, 16'h000C);
      rd(OFS_PAIR_STATUS); `CHK(d[POS_MISSED +: 2], 2'b00)
      @(posedge clock) gate_pin[0] <= ~gate_pin[0];
      wait_cyc(6);
      @(posedge clock) gate_pin[0] <= ~gate_pin[0];
      wait_cyc(6);
      rd(OFS_PAIR_STATUS);
      `CHK(d[POS_STALE], 1'b1)
      `CHK(d[POS_MISSED], 1'b1)
      rd(OFS_SAVE_OUTPUT); `CHK(d[POS_STICKY +: 2], 2'b01)
      rd(OFS_IRQ_STATUS); `CHK(d[3:2], 2'b01)
      wr(OFS_IRQ_STATUS, 16'h000C);
      rd(OFS_IRQ_STATUS); `CHK(d[3:2], 2'b00)
      @(posedge clock) load_command <= 2'b01;
      @(posedge clock) load_command <= 2'b00;
      rd(OFS_PAIR_STATUS); `CHK(d[POS_MISSED], 1'b0)
      @(posedge clock) source_pin[0] <= 1'b1;
      wait_cyc(6);
      @(posedge clock) load_done <= 2'b01;
      @(posedge clock) load_done <= 2'b00;
      @(posedge clock) gate_pin[0] <= ~gate_pin[0];
      wait_cyc(6);
      rd(OFS_PAIR_STATUS);
      `CHK(d[POS_STALE], 1'b0)
      `CHK(d[POS_MISSED], 1'b0)
      rd(OFS_SAVE_OUTPUT); `CHK(d[POS_STICKY +: 2], 2'b01)
      $display("test gate_flags done");
   endtask : t_gate_flags
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   initial begin
      arst_n = 1'b0; reg_write = 1'b0; reg_read = 1'b0; reg_addr = '0; reg_wdata = '0;
      gate_pin = 2'b00; gate_invert = 2'b00; source_pin = 2'b00; terminal_count = 2'b00;
      load_bank_in_use = 2'b00; hw_capture_latch = 2'b00; hw_capture_read = 2'b00;
      serial_busy = 1'b0; output_readback = 2'b00; counter_armed = 2'b00;
      load_command = 2'b00; load_done = 2'b00;
      wait_cyc(3);
      arst_n <= 1'b1;
      t_reset_values();
      t_live_status();
      t_soft_reset();
      t_tc_irq();
      t_overrun();
      t_capture();
      t_gate_flags();
      stop_test();
   end
endmodule : tb_cps_pair_status
